// [secondary_feedback_counter.v]
// Purpose: secondary position feedback, decode, count, scale and register port
// Assumes: all inputs synchronous to i_clk_sys; one request at a time on the register port
// Notes: scaled reads take a multi-cycle divide; o_reg_busy is high until the answer
`timescale 1ns/1ps
`default_nettype none
`include "secondary_feedback_regs.vh"

module secondary_feedback_counter (
  input  wire        i_clk_sys,                 // system clock, 100 MHz
  input  wire        i_reset,                   // synchronous reset, active high
  input  wire        i_diff_line_a,             // differential connector line a
  input  wire        i_diff_line_b,             // differential connector line b
  input  wire        i_io_line_a,               // io connector opto line a
  input  wire        i_io_line_b,               // io connector opto line b
  input  wire [7:0]  i_count_direction_invert,  // nonzero negates the position
  input  wire [3:0]  i_encoder_emulation_mode,  // nonzero claims the differential connector
  input  wire [15:0] i_scaling_input_factor,    // scaling numerator
  input  wire [15:0] i_scaling_output_factor,   // scaling denominator
  input  wire        i_reg_req,                 // request strobe
  input  wire        i_reg_we,                  // high write, low read
  input  wire [15:0] i_reg_index,               // parameter index
  input  wire [63:0] i_reg_wdata,               // write value
  output wire        o_reg_busy,                // request not taken while high
  output reg         o_reg_ack,                 // one-cycle answer pulse
  output reg         o_reg_err,                 // answer is a refusal
  output reg  [63:0] o_reg_rdata,               // read value
  output wire        o_io_selected              // position follows the io connector
);

  // register port sequence: idle, divide for scaled reads, finish
  localparam [1:0] ST_IDLE   = 2'h0;  // waiting for a request
  localparam [1:0] ST_DIVIDE = 2'h1;  // scaling divide running
  localparam [1:0] ST_FINISH = 2'h2;  // sign, offset and answer

  // a refused write leaves every setting untouched
  // settings
  reg  [15:0] input_type_select_r;          // decode style
  reg  [63:0] secondary_position_offset_r;  // signed offset
  reg  [31:0] position_unit_select_r;       // counts or per revolution
  reg  [31:0] counts_per_revolution_r;      // resolution
  reg  [15:0] secondary_source_select_r;    // none, differential, opto

  // position accumulator
  reg  [31:0] count_r;  // signed raw count
  reg  [31:0] count_nxt;

  // divider state
  reg  [1:0]  state_r;
  reg  [5:0]  div_cnt_r;   // numerator bits consumed
  reg  [57:0] div_num_r;   // numerator shifting out high first
  reg  [34:0] div_rem_r;   // partial remainder
  reg  [57:0] div_quot_r;  // quotient shifting in
  reg  [33:0] div_den_r;   // captured divisor
  reg         div_neg_r;   // result is to be negated

  // decoder outputs
  wire        diff_step;
  wire        diff_down;
  wire        io_step;
  wire        io_down;
  wire        sel_step;
  wire        sel_down;
  wire        count_enable;
  wire        invert;

  // each connector keeps its own edge history, so a
  // source change never makes a false count
  // both connectors decode with the same input type
  pulse_decoder u_diff_decoder (
    .i_clk_sys    (i_clk_sys),
    .i_reset      (i_reset),
    .i_input_type (input_type_select_r[1:0]),
    .i_line_a     (i_diff_line_a),
    .i_line_b     (i_diff_line_b),
    .o_step       (diff_step),
    .o_down       (diff_down)
  );

  pulse_decoder u_io_decoder (
    .i_clk_sys    (i_clk_sys),
    .i_reset      (i_reset),
    .i_input_type (input_type_select_r[1:0]),
    .i_line_a     (i_io_line_a),
    .i_line_b     (i_io_line_b),
    .o_step       (io_step),
    .o_down       (io_down)
  );

  // an emulated output on the differential connector forces the opto inputs
  assign o_io_selected = (i_encoder_emulation_mode != `EMU_DIFF_FREE) ||
                         (secondary_source_select_r == `SRC_IO_OPTO);
  // source none freezes the count
  assign count_enable  = (secondary_source_select_r != `SRC_NONE);
  assign sel_step      = o_io_selected ? io_step : diff_step;
  // direction comes from the same connector as the step
  assign sel_down      = o_io_selected ? io_down : diff_down;
  assign invert        = (i_count_direction_invert != 8'h00);

  // accumulator next value, wraps at 32 bits
  always @* begin
    count_nxt = count_r;
    if (count_enable && sel_step) begin
      if (sel_down) begin
        count_nxt = count_r - 32'h00000001;
      end else begin
        count_nxt = count_r + 32'h00000001;
      end
    end
  end

  // raw count with sign and offset for counts mode
  // the 32-bit count wraps; reads see it sign-extended
  wire [63:0] count_wide    = {{32{count_r[31]}}, count_r};
  wire [63:0] count_signed  = invert ? (64'h0 - count_wide) : count_wide;
  wire [63:0] counts_report = count_signed + secondary_position_offset_r;

  // divide on the magnitude, sign restored afterwards
  // magnitude times input factor times thousandths
  wire [31:0] count_abs  = count_r[31] ? (32'h0 - count_r) : count_r;
  wire [47:0] prod_in    = {16'h0000, count_abs} * {32'h00000000, i_scaling_input_factor};
  wire [57:0] scaled_num = {10'h000, prod_in} * `MILLI_SCALE;
  // resolution times output factor is one revolution
  wire [33:0] scaled_den = {16'h0000, counts_per_revolution_r[17:0]} *
                           {18'h00000, i_scaling_output_factor};

  // one restoring divide step
  wire [34:0] rem_shift  = {div_rem_r[33:0], div_num_r[57]};
  wire        rem_fits   = (rem_shift >= {1'b0, div_den_r});
  wire [34:0] rem_next   = rem_fits ? (rem_shift - {1'b0, div_den_r}) : rem_shift;

  // scaled result with sign and offset
  wire [63:0] quot_wide  = {6'h00, div_quot_r};
  wire [63:0] quot_sign  = div_neg_r ? (64'h0 - quot_wide) : quot_wide;
  wire [63:0] unit_report = quot_sign + secondary_position_offset_r;

  // the limit is held in thousandths of a unit
  // offset range check in custom units, signed compare
  wire        off_in_range = ($signed(i_reg_wdata) <= $signed(`OFFSET_UNIT_LIMIT)) &&
                             ($signed(i_reg_wdata) >= -$signed(`OFFSET_UNIT_LIMIT));

  // request decode
  wire        take     = i_reg_req && (state_r == ST_IDLE);
  wire        units_on = (position_unit_select_r == `UNIT_PER_REV);
  assign o_reg_busy    = (state_r != ST_IDLE);

  // accumulator
  // count holds its value while no source is picked
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      count_r <= 32'h00000000;
    end else begin
      count_r <= count_nxt;
    end
  end

  // requests are taken only in idle; busy holds off
  // the next one, so one answer at most is pending
  // register port, settings and divider sequence
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      input_type_select_r         <= `RST_INPUT_TYPE;
      secondary_position_offset_r <= `RST_POSITION_OFFSET;
      position_unit_select_r      <= `RST_POSITION_UNIT;
      counts_per_revolution_r     <= `RST_COUNTS_PER_REV;
      secondary_source_select_r   <= `RST_SOURCE_SELECT;
      state_r                     <= ST_IDLE;
      div_cnt_r                   <= 6'h00;
      div_num_r                   <= 58'h0;
      div_rem_r                   <= 35'h0;
      div_quot_r                  <= 58'h0;
      div_den_r                   <= 34'h0;
      div_neg_r                   <= 1'b0;
      o_reg_ack                   <= 1'b0;
      o_reg_err                   <= 1'b0;
      o_reg_rdata                 <= 64'h0;
    end else begin
      o_reg_ack <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (take && i_reg_we) begin
            // writes answer next cycle; a refused value leaves the setting alone
            o_reg_ack   <= 1'b1;
            o_reg_err   <= 1'b0;
            o_reg_rdata <= 64'h0;
            case (i_reg_index)
              `IDX_INPUT_TYPE: begin
                if (i_reg_wdata <= {48'h0, `TYPE_MAX}) begin
                  input_type_select_r <= i_reg_wdata[15:0];
                end else begin
                  o_reg_err <= 1'b1;
                end
              end
              `IDX_POSITION_UNIT: begin
                if ((i_reg_wdata == {32'h0, `UNIT_COUNTS}) ||
                    (i_reg_wdata == {32'h0, `UNIT_PER_REV})) begin
                  position_unit_select_r <= i_reg_wdata[31:0];
                end else begin
                  o_reg_err <= 1'b1;
                end
              end
              `IDX_POSITION_OFFSET: begin
                // custom units need the narrow range, counts take any 64-bit value
                if (!units_on || off_in_range) begin
                  secondary_position_offset_r <= i_reg_wdata;
                end else begin
                  o_reg_err <= 1'b1;
                end
              end
              `IDX_COUNTS_PER_REV: begin
                if (i_reg_wdata <= {32'h0, `COUNTS_PER_REV_MAX}) begin
                  counts_per_revolution_r <= i_reg_wdata[31:0];
                end else begin
                  o_reg_err <= 1'b1;
                end
              end
              `IDX_SOURCE_SELECT: begin
                if (i_reg_wdata <= {48'h0, `SRC_MAX}) begin
                  secondary_source_select_r <= i_reg_wdata[15:0];
                end else begin
                  o_reg_err <= 1'b1;
                end
              end
              default: begin
                // read-only position and unmapped indexes refuse writes
                o_reg_err <= 1'b1;
              end
            endcase
          end else if (take) begin
            // reads answer next cycle except the scaled position
            o_reg_ack   <= 1'b1;
            o_reg_err   <= 1'b0;
            o_reg_rdata <= 64'h0;
            case (i_reg_index)
              `IDX_INPUT_TYPE: begin
                o_reg_rdata <= {48'h0, input_type_select_r};
              end
              `IDX_POSITION_UNIT: begin
                o_reg_rdata <= {32'h0, position_unit_select_r};
              end
              `IDX_POSITION_OFFSET: begin
                o_reg_rdata <= secondary_position_offset_r;
              end
              `IDX_COUNTS_PER_REV: begin
                o_reg_rdata <= {32'h0, counts_per_revolution_r};
              end
              `IDX_SOURCE_SELECT: begin
                o_reg_rdata <= {48'h0, secondary_source_select_r};
              end
              `IDX_POSITION: begin
                if (!units_on) begin
                  o_reg_rdata <= counts_report;
                end else if (scaled_den == 34'h0) begin
                  // no resolution or output factor, scaling undefined
                  o_reg_err <= 1'b1;
                end else begin
                  // snapshot the count and start the divide; err and rdata
                  // keep the last answer until this read answers
                  o_reg_ack  <= 1'b0;
                  o_reg_err  <= o_reg_err;
                  o_reg_rdata <= o_reg_rdata;
                  state_r    <= ST_DIVIDE;
                  div_cnt_r  <= 6'h00;
                  div_num_r  <= scaled_num;
                  div_rem_r  <= 35'h0;
                  div_quot_r <= 58'h0;
                  div_den_r  <= scaled_den;
                  div_neg_r  <= count_r[31] ^ invert;
                end
              end
              default: begin
                // unmapped index reads zero with a refusal
                o_reg_err <= 1'b1;
              end
            endcase
          end
        end
        ST_DIVIDE: begin
          // one quotient bit per cycle
          // 58 numerator bits, so 58 steps give the full quotient
          div_rem_r  <= rem_next;
          div_num_r  <= {div_num_r[56:0], 1'b0};
          div_quot_r <= {div_quot_r[56:0], rem_fits};
          div_cnt_r  <= div_cnt_r + 6'h01;
          if (div_cnt_r == `DIV_LAST) begin
            state_r <= ST_FINISH;
          end
        end
        ST_FINISH: begin
          // apply sign and offset, then answer
          // busy drops here, so a new request may meet the answer
          o_reg_rdata <= unit_report;
          o_reg_err   <= 1'b0;
          o_reg_ack   <= 1'b1;
          state_r     <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // secondary_feedback_counter

`default_nettype wire

// [secondary_feedback_regs.vh]
// Purpose: constants for the secondary feedback counter: parameter indexes, field codes, limits
// Assumes: register indexes are fieldbus parameter indexes used as plain word addresses
// Notes:
// Operation
// - input type picks quadrature, step-direction or up-down
// - input type governs both physical secondary inputs
// - report position from connector chosen by emulation
// - position readable as counts or scaled units
// - direction one negates reported position
// - signed 64-bit offset added to reported position
// - custom-unit offset limited to plus/minus 10485760.000
// - unit setting accepts only 0 or 3
// - resolution up to 262140 counts per revolution
// - source selects none, differential or opto inputs
`ifndef SECONDARY_FEEDBACK_REGS_VH
`define SECONDARY_FEEDBACK_REGS_VH

// parameter indexes on the register port
`define IDX_COUNTS_PER_REV     16'h03d8
`define IDX_INPUT_TYPE         16'h03da
`define IDX_SOURCE_SELECT      16'h03dc
`define IDX_POSITION           16'h0660
`define IDX_POSITION_OFFSET    16'h0666
`define IDX_POSITION_UNIT      16'h066c

// reset values
`define RST_INPUT_TYPE         16'h0000
`define RST_POSITION_OFFSET    64'h0000000000000000
`define RST_POSITION_UNIT      32'h00000000
`define RST_COUNTS_PER_REV     32'h00000000
`define RST_SOURCE_SELECT      16'h0000

// input type codes
`define TYPE_QUADRATURE        2'h0
`define TYPE_STEP_DIR          2'h1
`define TYPE_UP_DOWN           2'h2
`define TYPE_MAX               16'h0002

// position unit codes
`define UNIT_COUNTS            32'h00000000
`define UNIT_PER_REV           32'h00000003

// source select codes
`define SRC_NONE               16'h0000
`define SRC_DIFFERENTIAL       16'h0001
`define SRC_IO_OPTO            16'h0002
`define SRC_MAX                16'h0002

// emulation mode value that leaves the differential connector free as an input
`define EMU_DIFF_FREE          4'h0

// limits
`define COUNTS_PER_REV_MAX     32'h0003fffc
`define OFFSET_UNIT_LIMIT      64'h0000000271000000
`define MILLI_SCALE            58'h0000000000003e8

// divider length in cycles, one per numerator bit
`define DIV_BITS               6'h3a
`define DIV_LAST               6'h39

`endif

// [pulse_decoder.v]
// Purpose: turns one pair of incremental input lines into count steps with a direction
// Assumes: lines are already synchronous to i_clk_sys
// Notes: one copy per physical connector so both follow the same input type
`timescale 1ns/1ps
`default_nettype none
`include "secondary_feedback_regs.vh"

module pulse_decoder (
  input  wire       i_clk_sys,
  input  wire       i_reset,
  input  wire [1:0] i_input_type,   // decode style
  input  wire       i_line_a,       // phase a, step or up line
  input  wire       i_line_b,       // phase b, direction or down line
  output reg        o_step,         // one-cycle pulse per count
  output reg        o_down          // direction of o_step, high counts down
);

  reg a_r;  // line a one cycle ago
  reg b_r;  // line b one cycle ago
  reg step_nxt;
  reg down_nxt;

  // edge and phase decode against the previous sample
  always @* begin
    step_nxt = 1'b0;
    down_nxt = 1'b0;
    case (i_input_type)
      `TYPE_QUADRATURE: begin
        // exactly one phase moved; both moving at once is a lost state and is dropped
        step_nxt = (i_line_a ^ a_r) ^ (i_line_b ^ b_r);
        down_nxt = ~(i_line_a ^ b_r);
      end
      `TYPE_STEP_DIR: begin
        // rising step edge counts, direction high means down
        step_nxt = i_line_a & ~a_r;
        down_nxt = i_line_b;
      end
      `TYPE_UP_DOWN: begin
        // simultaneous up and down edges cancel
        step_nxt = (i_line_a & ~a_r) ^ (i_line_b & ~b_r);
        down_nxt = i_line_b & ~b_r;
      end
      default: begin
        step_nxt = 1'b0;
        down_nxt = 1'b0;
      end
    endcase
  end

  // sample history and registered step outputs
  always @(posedge i_clk_sys) begin
    if (i_reset) begin
      a_r    <= 1'b0;
      b_r    <= 1'b0;
      o_step <= 1'b0;
      o_down <= 1'b0;
    end else begin
      a_r    <= i_line_a;
      b_r    <= i_line_b;
      o_step <= step_nxt;
      o_down <= down_nxt;
    end
  end

endmodule // pulse_decoder

`default_nettype wire

// [secondary_feedback_counter_sva.sv]
// Purpose: concurrent checks on the register port and connector choice of the counter
// Assumes: sees only the top module ports; one clock domain
// Notes: bound from the testbench top file
`timescale 1ns/1ps
`default_nettype none
`include "secondary_feedback_regs.vh"
module secondary_feedback_counter_sva (
  input wire logic        i_clk_sys,
  input wire logic        i_reset,
  input wire logic [3:0]  i_encoder_emulation_mode,
  input wire logic        i_reg_req,
  input wire logic        i_reg_we,
  input wire logic [15:0] i_reg_index,
  input wire logic [63:0] i_reg_wdata,
  input wire logic        o_reg_busy,
  input wire logic        o_reg_ack,
  input wire logic        o_reg_err,
  input wire logic [63:0] o_reg_rdata,
  input wire logic        o_io_selected
);
  logic       take;        // request taken at this edge
  logic       mapped;      // index names a register
  logic [7:0] busy_cnt_r;  // consecutive busy samples
  assign take = i_reg_req && !o_reg_busy;
  assign mapped = i_reg_index inside {`IDX_COUNTS_PER_REV, `IDX_INPUT_TYPE, `IDX_SOURCE_SELECT,
                                      `IDX_POSITION, `IDX_POSITION_OFFSET, `IDX_POSITION_UNIT};
  // length of the divide window of a scaled read
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) busy_cnt_r <= 8'h00;
    else if (o_reg_busy) busy_cnt_r <= busy_cnt_r + 8'h01;
    else busy_cnt_r <= 8'h00;
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  a_write_ack_next: assert property (take && i_reg_we |=> o_reg_ack && o_reg_rdata == 64'h0)
    else $error("write not answered next cycle");
  a_position_write_refused: assert property (take && i_reg_we && i_reg_index == `IDX_POSITION |=> o_reg_err)
    else $error("position write not refused");
  a_unmapped_refused: assert property (take && !mapped |=> o_reg_ack && o_reg_err && o_reg_rdata == 64'h0)
    else $error("unmapped index not refused");
  a_type_range: assert property (take && i_reg_we && i_reg_index == `IDX_INPUT_TYPE && i_reg_wdata == 64'h3
    |=> o_reg_err)
    else $error("input type 3 accepted");
  a_unit_range: assert property (take && i_reg_we && i_reg_index == `IDX_POSITION_UNIT
    && i_reg_wdata != 64'h0 && i_reg_wdata != 64'h3 |=> o_reg_err)
    else $error("bad unit accepted");
  a_scaled_read_length: assert property ($fell(o_reg_busy) |-> o_reg_ack && busy_cnt_r == 8'h3b)
    else $error("scaled read length wrong");
  a_ack_single: assert property (o_reg_ack && !take |=> !o_reg_ack)
    else $error("answer longer than one cycle");
  a_no_stray_ack: assert property (!take && !o_reg_busy |=> !o_reg_ack)
    else $error("answer without request");
  a_answer_held: assert property (!o_reg_ack |-> $stable(o_reg_err) && $stable(o_reg_rdata))
    else $error("answer changed between answers");
  a_io_follows_emulation: assert property (i_encoder_emulation_mode != 4'h0 |-> o_io_selected)
    else $error("emulation did not select io connector");
endmodule // secondary_feedback_counter_sva
`default_nettype wire

// [encoder_source.sv]
// Purpose: far-side pulse source for one secondary connector
// Assumes: one count per i_move pulse, next pulse at least 4 cycles later
// Notes: step-direction leaves the direction line standing, as a real source does
`timescale 1ns/1ps
`default_nettype none
module encoder_source (
  input  wire logic       i_clk_sys,
  input  wire logic [1:0] i_style,   // 0 quadrature, 1 step-direction, 2 up-down
  input  wire logic       i_move,    // start one count
  input  wire logic       i_down,    // count down
  output var  logic       o_line_a,
  output var  logic       o_line_b
);
  logic [1:0] q_r;   // quadrature state index
  logic [1:0] nq;    // next quadrature state
  logic [1:0] ph_r;  // phase of the current count
  logic       dn_r;  // latched direction
  assign nq = dn_r ? q_r - 2'h1 : q_r + 2'h1;
  initial begin
    q_r = 2'h0;
    ph_r = 2'h0;
    dn_r = 1'b0;
    o_line_a = 1'b0;
    o_line_b = 1'b0;
  end
  // one count in up to three phases
  always @(posedge i_clk_sys) begin
    case (ph_r)
      2'h0: if (i_move) begin
        ph_r <= 2'h1;
        dn_r <= i_down;
      end
      2'h1: begin
        ph_r <= 2'h2;
        if (i_style == 2'h0) begin  // one phase moves, a leads b upward
          q_r <= nq;
          o_line_a <= nq[1] ^ nq[0];
          o_line_b <= nq[1];
        end else if (i_style == 2'h1) o_line_b <= dn_r;  // direction settles first
      end
      2'h2: begin
        ph_r <= 2'h3;
        if (i_style == 2'h1) o_line_a <= 1'b1;  // step edge
        else if (i_style == 2'h2) begin  // up or down line pulses
          if (dn_r) o_line_b <= 1'b1;
          else o_line_a <= 1'b1;
        end
      end
      default: begin
        ph_r <= 2'h0;
        if (i_style != 2'h0) o_line_a <= 1'b0;
        if (i_style == 2'h2) o_line_b <= 1'b0;
      end
    endcase
  end
endmodule // encoder_source
`default_nettype wire

// [secondary_feedback_counter_test.sv]
// Purpose: self-checking bench for the secondary feedback counter
// Assumes: answers as in the hand-over; two pulse sources on the connectors
// Notes: position kept in cnt; each burst nets four counts and leaves lines low
`timescale 1ns/1ps
`default_nettype none
`include "secondary_feedback_regs.vh"
module secondary_feedback_counter_test;
  logic        i_clk_sys, i_reset, i_reg_req, i_reg_we, o_reg_busy, o_reg_ack, o_reg_err, o_io_selected;
  logic        da, db, ia, ib, mv_d, mv_i, dn;
  logic [1:0]  style;
  logic [3:0]  emu;
  logic [7:0]  inv;
  logic [15:0] i_reg_index, fin, fout;
  logic [63:0] i_reg_wdata, o_reg_rdata, rv;
  logic        re;
  int          n_mismatch, checked, cnt, cyc;
  secondary_feedback_counter secondary_feedback_counter_i (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
    .i_diff_line_a(da), .i_diff_line_b(db), .i_io_line_a(ia), .i_io_line_b(ib),
    .i_count_direction_invert(inv), .i_encoder_emulation_mode(emu), .i_scaling_input_factor(fin),
    .i_scaling_output_factor(fout), .i_reg_req(i_reg_req), .i_reg_we(i_reg_we), .i_reg_index(i_reg_index),
    .i_reg_wdata(i_reg_wdata), .o_reg_busy(o_reg_busy), .o_reg_ack(o_reg_ack), .o_reg_err(o_reg_err),
    .o_reg_rdata(o_reg_rdata), .o_io_selected(o_io_selected));
  encoder_source diff_src_i (.i_clk_sys(i_clk_sys), .i_style(style), .i_move(mv_d), .i_down(dn),
    .o_line_a(da), .o_line_b(db));
  encoder_source io_src_i (.i_clk_sys(i_clk_sys), .i_style(style), .i_move(mv_i), .i_down(dn),
    .o_line_a(ia), .o_line_b(ib));
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one register request, strobed for one cycle only, answer caught at ack
  task automatic xfer(input logic w, input logic [15:0] x, input logic [63:0] d);
    int n;
    @(posedge i_clk_sys);
    i_reg_req <= 1'b1;
    i_reg_we <= w;
    i_reg_index <= x;
    i_reg_wdata <= d;
    @(posedge i_clk_sys);
    i_reg_req <= 1'b0;
    n = 0;
    do begin
      @(posedge i_clk_sys);
      n++;
    end while (o_reg_ack !== 1'b1 && n < 100);
    rv = o_reg_rdata;
    re = o_reg_err;
    chk({63'h0, o_reg_ack}, 64'h1);
  endtask
  task automatic wr_ok(input logic [15:0] x, input logic [63:0] d, input logic e);
    xfer(1'b1, x, d);
    chk({63'h0, re}, {63'h0, e});
  endtask
  task automatic rdpos(input longint e);
    xfer(1'b0, `IDX_POSITION, 64'h0);
    chk(rv, e);
  endtask
  // one down then five up on one connector
  task automatic burst(input logic on_io);
    for (int k = 0; k < 6; k++) begin
      @(posedge i_clk_sys);
      mv_i <= on_io;
      mv_d <= !on_io;
      dn <= (k == 0);
      @(posedge i_clk_sys);
      mv_i <= 1'b0;
      mv_d <= 1'b0;
      repeat (6) @(posedge i_clk_sys);
    end
  endtask
  task automatic t_reset_values;
    logic [15:0] tbl [6] = '{`IDX_COUNTS_PER_REV, `IDX_INPUT_TYPE, `IDX_SOURCE_SELECT,
                             `IDX_POSITION_OFFSET, `IDX_POSITION_UNIT, `IDX_POSITION};
    foreach (tbl[i]) begin
      xfer(1'b0, tbl[i], 64'h0);
      chk(rv, 64'h0);
    end
    $display("reset values done");
  endtask
  task automatic t_refusals;
    logic [15:0] ix [6] = '{16'h1234, `IDX_POSITION, `IDX_INPUT_TYPE, `IDX_POSITION_UNIT,
                            `IDX_SOURCE_SELECT, `IDX_COUNTS_PER_REV};
    logic [63:0] dv [6] = '{64'h1, 64'h5, 64'h3, 64'h1, 64'h3, 64'h3fffd};
    foreach (ix[i]) wr_ok(ix[i], dv[i], 1'b1);
    xfer(1'b0, 16'h1234, 64'h0);
    chk({63'h0, re}, 64'h1);
    chk(rv, 64'h0);
    xfer(1'b0, `IDX_INPUT_TYPE, 64'h0);
    chk(rv, 64'h0);
    wr_ok(`IDX_COUNTS_PER_REV, 64'h3fffc, 1'b0);
    $display("refusals done");
  endtask
  task automatic t_modes;
    for (int t = 0; t < 3; t++) begin
      for (int s = 1; s < 3; s++) begin
        wr_ok(`IDX_INPUT_TYPE, 64'(t), 1'b0);
        wr_ok(`IDX_SOURCE_SELECT, 64'(s), 1'b0);
        style <= 2'(t);
        burst(s == 2);
        cnt += 4;
        rdpos(cnt);
      end
    end
    $display("input types done");
  endtask
  task automatic t_select;
    emu <= 4'h1;
    wr_ok(`IDX_SOURCE_SELECT, 64'h1, 1'b0);
    burst(1'b0);
    rdpos(cnt);
    burst(1'b1);
    cnt += 4;
    rdpos(cnt);
    chk({63'h0, o_io_selected}, 64'h1);
    emu <= 4'h0;
    wr_ok(`IDX_SOURCE_SELECT, 64'h0, 1'b0);
    burst(1'b1);
    rdpos(cnt);
    $display("connector choice done");
  endtask
  task automatic t_invert_offset;
    wr_ok(`IDX_POSITION_OFFSET, -64'sd5, 1'b0);
    inv <= 8'h01;
    rdpos(-cnt - 5);
    inv <= 8'h00;
    rdpos(cnt - 5);
    $display("invert and offset done");
  endtask
  task automatic t_scaled;
    wr_ok(`IDX_POSITION_UNIT, 64'h3, 1'b0);
    wr_ok(`IDX_COUNTS_PER_REV, 64'h0, 1'b0);
    xfer(1'b0, `IDX_POSITION, 64'h0);
    chk({63'h0, re}, 64'h1);
    chk(rv, 64'h0);
    wr_ok(`IDX_COUNTS_PER_REV, 64'h3e8, 1'b0);
    fin <= 16'h0003;
    fout <= 16'h0002;
    inv <= 8'h01;
    rdpos(-((cnt * 3000) / 2000) - 5);
    inv <= 8'h00;
    wr_ok(`IDX_POSITION_OFFSET, 64'h271000001, 1'b1);
    wr_ok(`IDX_POSITION_OFFSET, -64'sh271000000, 1'b0);
    rdpos((cnt * 3000) / 2000 - 64'sh271000000);
    $display("scaled units done");
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // hang guard
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      conclude();
    end
  end
  initial begin
    {i_reset, i_reg_req, i_reg_we, i_reg_index, i_reg_wdata} = {1'b1, 82'h0};
    {mv_d, mv_i, dn, style, emu, inv, fin, fout} = {17'h0, 32'h00010001};
    {n_mismatch, checked, cnt, cyc} = {32'h0, 32'h0, 32'h0, 32'h0};
    repeat (8) @(posedge i_clk_sys);
    i_reset <= 1'b0;
    t_reset_values();
    t_refusals();
    t_modes();
    t_select();
    t_invert_offset();
    t_scaled();
    conclude();
  end
endmodule // secondary_feedback_counter_test
bind secondary_feedback_counter secondary_feedback_counter_sva secondary_feedback_counter_sva_i (
  .i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_encoder_emulation_mode(i_encoder_emulation_mode),
  .i_reg_req(i_reg_req), .i_reg_we(i_reg_we), .i_reg_index(i_reg_index), .i_reg_wdata(i_reg_wdata),
  .o_reg_busy(o_reg_busy), .o_reg_ack(o_reg_ack), .o_reg_err(o_reg_err), .o_reg_rdata(o_reg_rdata),
  .o_io_selected(o_io_selected));
`default_nettype wire
